// [include/bbce_pkg.sv]
/*
 * bbce_pkg: constants for the bank/blink command executor.
 * assumes: bytes arrive already deframed from the serial slave.
 */
package bbce_pkg;
    // ****************************************
    // command opcodes
    // ****************************************
    localparam logic [5:0] BBCE_BANK_OP = 6'h3e;
    localparam logic [4:0] BBCE_BLINK_OP = 5'h1e;
    localparam int BBCE_BANK_IN_BIT = 1;
    localparam int BBCE_BANK_OUT_BIT = 0;
    localparam int BBCE_BLINK_MODE_BIT = 2;
    // ****************************************
    // control byte fields
    // ****************************************
    localparam int BBCE_CTL_MORE_BIT = 7;
    localparam int BBCE_CTL_KIND_BIT = 6;
    // ****************************************
    // drive modes and reset values
    // ****************************************
    typedef enum logic [1:0] {
        BBCE_MODE_1TO4 = 2'b00,
        BBCE_MODE_STATIC = 2'b01,
        BBCE_MODE_1TO2 = 2'b10,
        BBCE_MODE_1TO3 = 2'b11
    } bbce_mode_e;
    localparam logic [1:0] BBCE_FREQ_RST = 2'h0;
    localparam logic BBCE_BANK_RST = 1'b0;
    localparam logic BBCE_BMODE_RST = 1'b0;
endpackage

// [design/bbce_top.sv]
/*
 * bbce_top: bank-select / blink-select executor and RAM storage order.
 * assumes: one byte per i_byte_vld pulse; i_byte_first marks the first
 * byte after the address. drive mode comes from the mode-set logic.
 */
`timescale 1ns/10ps
`default_nettype none
module bbce_top
    import bbce_pkg::*;
(
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_ce,
    // byte stream
    input wire logic i_byte_vld,
    input wire logic i_byte_first,
    input wire logic [7:0] i_byte,
    // drive mode from mode-set
    input wire logic [1:0] i_drive_mode,
    // settings
    output logic o_in_bank,
    output logic o_out_bank,
    output logic o_blink_alt,
    output logic [1:0] o_blink_freq_sel,
    // ram write for one data nibble column
    output logic o_ram_we,
    output logic [3:0] o_ram_wmask,
    output logic [3:0] o_ram_wdata,
    // ram read plane select for the lcd drivers
    output logic [3:0] o_ram_rmask
);
    import bbce_pkg::*;
    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        logic in_bank;
        logic out_bank;
        logic blink_alt;
        logic [1:0] freq;
        logic ctl_next;
        logic more_control_flag;
        logic byte_kind_select;
        logic we;
        logic [3:0] wmask;
        logic [3:0] wdata;
    } bbce_state_s;
    bbce_state_s st_r, st_nxt;

    // planes for a bank in a mode; 1:3/1:4 use all four
    function automatic logic [3:0] bank_mask(input logic [1:0] mode, input logic bank);
        case (mode)
            BBCE_MODE_STATIC: bank_mask = bank ? 4'h4 : 4'h1;
            BBCE_MODE_1TO2: bank_mask = bank ? 4'hc : 4'h3;
            default: bank_mask = 4'hf;
        endcase
    endfunction

    logic multi_hi;
    assign multi_hi = (i_drive_mode == BBCE_MODE_1TO3) || (i_drive_mode == BBCE_MODE_1TO4);

    always_comb begin
        st_nxt = st_r;
        st_nxt.we = 1'b0;
        if (i_byte_vld) begin
            if (i_byte_first || st_r.ctl_next) begin
                // control byte
                st_nxt.more_control_flag = i_byte[BBCE_CTL_MORE_BIT];
                st_nxt.byte_kind_select = i_byte[BBCE_CTL_KIND_BIT];
                st_nxt.ctl_next = 1'b0;
            end else begin
                // with more_control_flag set, a control byte follows each payload
                st_nxt.ctl_next = st_r.more_control_flag;
                if (st_r.byte_kind_select) begin
                    st_nxt.we = 1'b1;
                    st_nxt.wmask = bank_mask(i_drive_mode, st_r.in_bank);
                    st_nxt.wdata = i_byte[3:0];
                end else if (i_byte[7:2] == BBCE_BANK_OP) begin
                    if (!multi_hi) begin
                        st_nxt.in_bank = i_byte[BBCE_BANK_IN_BIT];
                        st_nxt.out_bank = i_byte[BBCE_BANK_OUT_BIT];
                    end
                end else if (i_byte[7:3] == BBCE_BLINK_OP) begin
                    st_nxt.blink_alt = i_byte[BBCE_BLINK_MODE_BIT];
                    st_nxt.freq = i_byte[1:0];
                end
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st_r <= '0;
            st_r.in_bank <= BBCE_BANK_RST;
            st_r.out_bank <= BBCE_BANK_RST;
            st_r.blink_alt <= BBCE_BMODE_RST;
            st_r.freq <= BBCE_FREQ_RST;
        end else if (i_ce) begin
            st_r <= st_nxt;
        end
    end

    assign o_in_bank = st_r.in_bank;
    assign o_out_bank = st_r.out_bank;
    assign o_blink_alt = st_r.blink_alt;
    assign o_blink_freq_sel = st_r.freq;
    assign o_ram_we = st_r.we;
    assign o_ram_wmask = st_r.wmask;
    assign o_ram_wdata = st_r.wdata;
    // in 1:3/1:4 the stored bank bit has no effect on reads
    assign o_ram_rmask = bank_mask(i_drive_mode, st_r.out_bank);

    // ****************************************
    // checks
    // ****************************************
    logic cmd_byte;
    assign cmd_byte = i_ce && i_byte_vld && !i_byte_first && !st_r.ctl_next
        && !st_r.byte_kind_select;
    sequence s_bank_cmd;
        cmd_byte && i_byte[7:2] == BBCE_BANK_OP && !multi_hi;
    endsequence
    property p_bank_in;
        @(posedge i_clk) disable iff (!i_rst_n)
        s_bank_cmd |=> o_in_bank == $past(i_byte[1]);
    endproperty
    a_bank_in: assert property (p_bank_in) else $error("input bank not taken");
    property p_bank_out;
        @(posedge i_clk) disable iff (!i_rst_n)
        s_bank_cmd |=> o_out_bank == $past(i_byte[0]);
    endproperty
    a_bank_out: assert property (p_bank_out) else $error("output bank not taken");
    property p_bank_ignored;
        @(posedge i_clk) disable iff (!i_rst_n)
        (cmd_byte && i_byte[7:2] == BBCE_BANK_OP && multi_hi) |=> $stable(o_in_bank)
            && $stable(o_out_bank);
    endproperty
    a_bank_ignored: assert property (p_bank_ignored) else $error("bank cmd acted");
    property p_blink;
        @(posedge i_clk) disable iff (!i_rst_n)
        (cmd_byte && i_byte[7:3] == BBCE_BLINK_OP) |=> o_blink_alt == $past(i_byte[2])
            && o_blink_freq_sel == $past(i_byte[1:0]);
    endproperty
    a_blink: assert property (p_blink) else $error("blink select not taken");
    property p_static_wmask;
        @(posedge i_clk) disable iff (!i_rst_n)
        (o_ram_we && $past(i_ce) && i_drive_mode == BBCE_MODE_STATIC && $stable(i_drive_mode))
            |-> o_ram_wmask == (o_in_bank ? 4'h4 : 4'h1);
    endproperty
    a_static_wmask: assert property (p_static_wmask) else $error("bad write planes");
    property p_ctl_kind;
        @(posedge i_clk) disable iff (!i_rst_n)
        (i_ce && i_byte_vld && i_byte_first) |=> st_r.byte_kind_select == $past(i_byte[6])
            && !o_ram_we;
    endproperty
    a_ctl_kind: assert property (p_ctl_kind) else $error("control byte misread");
    property p_mode_rmask;
        @(posedge i_clk) disable iff (!i_rst_n)
        multi_hi |-> o_ram_rmask == 4'hf;
    endproperty
    a_mode_rmask: assert property (p_mode_rmask) else $error("rmask in 1:3/1:4");
    property p_data_write;
        @(posedge i_clk) disable iff (!i_rst_n)
        (i_ce && i_byte_vld && !i_byte_first && !st_r.ctl_next && st_r.byte_kind_select)
            |=> o_ram_we && o_ram_wdata == $past(i_byte[3:0]);
    endproperty
    a_data_write: assert property (p_data_write) else $error("data not written");

    // ****************************************
    // storage order, hold and chaining checks
    // ****************************************
    logic pay_byte;
    assign pay_byte = i_ce && i_byte_vld && !i_byte_first && !st_r.ctl_next;
    property p_duplex_wmask;
        @(posedge i_clk) disable iff (!i_rst_n)
        (o_ram_we && $past(i_ce) && i_drive_mode == BBCE_MODE_1TO2 && $stable(i_drive_mode))
            |-> o_ram_wmask == (o_in_bank ? 4'hc : 4'h3);
    endproperty
    a_duplex_wmask: assert property (p_duplex_wmask) else $error("bad duplex planes");
    // 1:3 and 1:4 keep all four planes per column, whatever the stored bank
    property p_multi_wmask;
        @(posedge i_clk) disable iff (!i_rst_n)
        (o_ram_we && $past(i_ce) && multi_hi && $past(multi_hi)) |-> o_ram_wmask == 4'hf;
    endproperty
    a_multi_wmask: assert property (p_multi_wmask) else $error("wide mode planes");
    property p_we_pulse;
        @(posedge i_clk) disable iff (!i_rst_n)
        (o_ram_we && i_ce && !(pay_byte && st_r.byte_kind_select)) |=> !o_ram_we;
    endproperty
    a_we_pulse: assert property (p_we_pulse) else $error("write strobe stuck");
    property p_static_rmask;
        @(posedge i_clk) disable iff (!i_rst_n)
        (i_drive_mode == BBCE_MODE_STATIC) |-> o_ram_rmask == (o_out_bank ? 4'h4 : 4'h1);
    endproperty
    a_static_rmask: assert property (p_static_rmask) else $error("static read planes");
    property p_duplex_rmask;
        @(posedge i_clk) disable iff (!i_rst_n)
        (i_drive_mode == BBCE_MODE_1TO2) |-> o_ram_rmask == (o_out_bank ? 4'hc : 4'h3);
    endproperty
    a_duplex_rmask: assert property (p_duplex_rmask) else $error("duplex read planes");
    // a chained control byte must follow each payload while the more flag is set
    sequence s_pay_more;
        pay_byte && st_r.more_control_flag;
    endsequence
    sequence s_ctl_byte;
        i_ce && i_byte_vld && (i_byte_first || st_r.ctl_next);
    endsequence
    property p_ctl_chain;
        @(posedge i_clk) disable iff (!i_rst_n)
        s_pay_more |=> st_r.ctl_next;
    endproperty
    a_ctl_chain: assert property (p_ctl_chain) else $error("chained control missed");
    property p_ctl_taken;
        @(posedge i_clk) disable iff (!i_rst_n)
        s_ctl_byte |=> st_r.more_control_flag == $past(i_byte[BBCE_CTL_MORE_BIT])
            && !st_r.ctl_next && !o_ram_we;
    endproperty
    a_ctl_taken: assert property (p_ctl_taken) else $error("control flags misread");
    // settings move only on an accepted command byte, never on data or idle
    property p_settings_hold;
        @(posedge i_clk) disable iff (!i_rst_n)
        !cmd_byte |=> $stable(o_in_bank) && $stable(o_out_bank) && $stable(o_blink_alt)
            && $stable(o_blink_freq_sel);
    endproperty
    a_settings_hold: assert property (p_settings_hold) else $error("setting changed");
    property p_ce_freeze;
        @(posedge i_clk) disable iff (!i_rst_n)
        !i_ce |=> $stable(st_r);
    endproperty
    a_ce_freeze: assert property (p_ce_freeze) else $error("state moved, enable low");
endmodule
`default_nettype wire

// [dv/bbce_master.sv]
/* bbce_master: byte-level model of the bus master.
   assumes: bytes arrive deframed; inputs change on falling edges. */
`timescale 1ns/10ps
`default_nettype none
module bbce_master (
    // clock and byte stream
    input wire logic i_clk,
    output logic o_vld = 1'b0,
    output logic o_first = 1'b0,
    output logic [7:0] o_byte = 8'h00
);
    task automatic put(input logic f, input logic [7:0] b);
        @(negedge i_clk);
        o_vld = 1'b1;
        o_first = f;
        o_byte = b;
        @(negedge i_clk);
        o_vld = 1'b0;
        o_first = 1'b0;
        o_byte = ~b; // idle bus must not echo the last byte
    endtask
    // last control byte, so every later byte is payload of one kind
    task automatic xfer(input logic dat, input logic [7:0] b);
        put(1'b1, {1'b0, dat, 6'h00});
        put(1'b0, b);
    endtask
endmodule
`default_nettype wire

// [dv/bbce_top_test.sv]
/* bbce_top_test: self-checking bench for bbce_top.
   assumes: bbce_master sends bytes; the bench sets the drive mode. */
`timescale 1ns/10ps
`default_nettype none
module bbce_top_test;
    logic clk = 1'b0, rst_n = 1'b0, ce = 1'b1, vld, fst, ib, ob, alt, we;
    logic [1:0] md = 2'b01, fq;
    logic [7:0] bt;
    logic [3:0] wm, wd, rm;
    int err_count = 0, num_checks = 0;
    always #4 clk = ~clk;
    bbce_master u_bbce_master (.i_clk(clk), .o_vld(vld), .o_first(fst), .o_byte(bt));
    bbce_top u_bbce_top (.i_clk(clk), .i_rst_n(rst_n), .i_ce(ce), .i_byte_vld(vld),
        .i_byte_first(fst), .i_byte(bt), .i_drive_mode(md), .o_in_bank(ib),
        .o_out_bank(ob), .o_blink_alt(alt), .o_blink_freq_sel(fq), .o_ram_we(we),
        .o_ram_wmask(wm), .o_ram_wdata(wd), .o_ram_rmask(rm));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) err_count++;
        if (got !== exp) $display("[ERR] %0t got %h exp %h", $time, got, exp);
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // about 80 cycles suffice; the 2000-cycle limit only catches a hang
    initial begin
        repeat (2000) @(posedge clk);
        err_count++;
        test_done();
    end
    task automatic t_bank();
        u_bbce_master.xfer(1'b0, 8'hfa);
        chk({ib, ob, rm}, 6'h21);
        md = 2'b10;
        u_bbce_master.put(1'b0, 8'hf9);
        chk({ib, ob, rm}, 6'h1c);
        for (int m = 0; m < 4; m += 3) begin
            md = 2'(m);
            u_bbce_master.put(1'b0, 8'hfa);
            chk({ib, ob, rm}, 6'h1f);
        end
        $display("test bank done");
    endtask
    task automatic t_blink();
        md = 2'b01;
        for (int f = 0; f < 4; f++) begin
            u_bbce_master.put(1'b0, {bbce_pkg::BBCE_BLINK_OP, 1'b1, 2'(f)});
            chk({alt, fq}, {1'b1, 2'(f)});
        end
        md = 2'b00;
        u_bbce_master.put(1'b0, {bbce_pkg::BBCE_BLINK_OP, 3'h2});
        ce = 1'b0;
        u_bbce_master.put(1'b0, 8'hf5);
        ce = 1'b1;
        u_bbce_master.put(1'b0, 8'he5);
        chk({alt, fq}, 3'h2);
        $display("test blink done");
    endtask
    task automatic t_data();
        logic [3:0] m;
        for (int k = 0; k < 4; k++) begin
            md = k[1] ? 2'b10 : 2'b01;
            m = (k[1] ? 4'h3 : 4'h1) << (2 * k[0]);
            u_bbce_master.xfer(1'b0, {bbce_pkg::BBCE_BANK_OP, k[0], k[0]});
            u_bbce_master.xfer(1'b1, {4'ha, 4'(k + 5)});
            chk({we, wm, wd, rm}, {1'b1, m, 4'(k + 5), m});
            @(negedge clk);
            chk({7'h00, we}, 8'h00);
        end
        $display("test data done");
    endtask
    // chained control bytes, wide-mode write, then a reset in mid-run
    task automatic t_chain();
        md = 2'b00;
        u_bbce_master.put(1'b1, 8'h80);
        u_bbce_master.put(1'b0, 8'hf3);
        u_bbce_master.put(1'b0, 8'hc0);
        u_bbce_master.put(1'b0, 8'h09);
        chk({we, wm, wd, alt, fq}, {1'b1, 4'hf, 4'h9, 1'b0, 2'h3});
        u_bbce_master.put(1'b0, 8'h00);
        u_bbce_master.put(1'b0, 8'hf0);
        chk({we, alt, fq}, 4'h0);
        md = 2'b01;
        u_bbce_master.put(1'b0, 8'hf6);
        chk({ib, ob, alt, fq}, 5'h1e);
        rst_n = 1'b0;
        @(negedge clk);
        chk({ib, ob, alt, fq, we, rm}, 10'h001);
        rst_n = 1'b1;
        u_bbce_master.xfer(1'b0, 8'hfb);
        chk({ib, ob, rm}, 6'h34);
        $display("test chain done");
    endtask
    initial begin
        repeat (2) @(negedge clk);
        chk({ib, ob, alt, fq, we, rm}, 10'h001);
        rst_n = 1'b1;
        t_bank();
        t_blink();
        t_data();
        t_chain();
        test_done();
    end
endmodule
`default_nettype wire
